// ===== hcp_pkg.sv
// Constants and types shared by the host control port
package hcp_pkg;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int CLK_HZ = 50_000_000;
  // Least low time on the hardware reset pin
  localparam int RST_MIN_NS = 100;
  localparam int RST_CYC = (RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int RST_CNT_W = 3;
  // Time from reset release until registers answer
  localparam int READY_MS = 2;
  localparam int READY_CYC = READY_MS * (CLK_HZ / 1000);
  localparam int BOOT_W = 17;

  // ****************************************************
  // Bus widths and serial frame
  // ****************************************************
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int INT_W = 8;
  localparam int LINK_N = 4;
  // Serial frame: read flag, five spare bits, ten address bits, eight data bits
  localparam logic [4:0] SER_CMD_LAST = 5'h0f;
  localparam logic [4:0] SER_WR_LAST = 5'h17;
  localparam logic [4:0] SER_END = 5'h18;
  localparam int SER_RD_POS = 14;

  // ****************************************************
  // Registers
  // ****************************************************
  localparam logic [ADDR_W-1:0] GPCTL_ADDR = 10'h006;
  localparam int GP_DIR_LSB = 0;
  localparam int GP_LEVEL_LSB = 2;
  localparam logic [1:0] GP_DIR_RST = 2'h0;
  localparam logic [1:0] GP_LEVEL_RST = 2'h0;

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [2:0] {
    HCP_BOOT = 3'b001,
    HCP_IDLE = 3'b010,
    HCP_DONE = 3'b100
  } hcp_state_t;

  typedef struct packed {
    logic [1:0] level;
    logic [1:0] dir;
  } hcp_gpctl_t;

  // Pin samples that pass the synchroniser
  typedef struct packed {
    logic rst_n;
    logic cs_n;
    logic rw;
    logic strb;
    logic style;
    logic ser;
    logic flt;
    logic [1:0] gpio;
    logic [DATA_W-1:0] data;
    logic [ADDR_W-1:0] addr;
  } hcp_pins_t;

  typedef struct packed {
    hcp_pins_t s1;
    hcp_pins_t s2;
    hcp_pins_t s3;
    hcp_state_t state;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic [BOOT_W-1:0] boot_cnt;
    logic cs_seen;
    hcp_gpctl_t gpctl;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] drv;
    logic [DATA_W-1:0] oe;
    logic rd_pend;
    logic reg_rd;
    logic reg_wr;
    logic [15:0] shift;
    logic [4:0] bitcnt;
    logic ser_rd;
  } hcp_regs_t;

endpackage

// ===== hcp_host_control_port.sv
// Host control port: parallel and serial register access, GPIO, interrupt and line float
//
// Behaviour
// - Reset pin low over 100 ns resets
// - Registers answer only 2 ms after reset
// - Direction bits choose GPIO input or output
// - Level bits report input or drive output
// - Open-drain interrupt low while unmasked indications
// - Parallel address pins select the register
// - Parallel data on eight-bit two-way bus
// - Serial read data leaves on data bit 0
// - Style strap picks strobe style in parallel
// - Sample input on rise, change output on fall
// - Serial select pin picks serial or parallel
// - Float pin places all line outputs high-Z
`timescale 1ns/1ns
module hcp_host_control_port #(
  parameter int READY_CYC = hcp_pkg::READY_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Hardware reset pin
  input wire logic reset_pin_n,
  // Processor bus pins
  input wire logic cs_n,
  input wire logic [hcp_pkg::ADDR_W-1:0] addr,
  input wire logic [hcp_pkg::DATA_W-1:0] data_in,
  output logic [hcp_pkg::DATA_W-1:0] data_out,
  output logic [hcp_pkg::DATA_W-1:0] data_oe,
  input wire logic rw_wr_sdi,
  input wire logic transfer_strobe_n,
  input wire logic bus_style_select,
  input wire logic serial_host_select,
  // General purpose pins
  input wire logic [1:0] gpio_in,
  output logic [1:0] gpio_out,
  output logic [1:0] gpio_oe,
  // Interrupt pin and its sources
  input wire logic [hcp_pkg::INT_W-1:0] int_flags,
  input wire logic [hcp_pkg::INT_W-1:0] int_mask,
  output logic int_n_out,
  output logic int_oe,
  // Line output float
  input wire logic line_out_float,
  output logic [hcp_pkg::LINK_N-1:0] tx_hiz,
  // Core register port
  output logic [hcp_pkg::ADDR_W-1:0] reg_addr,
  output logic [hcp_pkg::DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [hcp_pkg::DATA_W-1:0] reg_rdata,
  output logic regs_ready
);

  // ****************************************************
  // State
  // ****************************************************
  hcp_pkg::hcp_regs_t st;
  hcp_pkg::hcp_regs_t next_st;
  hcp_pkg::hcp_pins_t pins_now;

  function automatic logic [hcp_pkg::DATA_W-1:0] gp_read(input hcp_pkg::hcp_gpctl_t g,
                                                       input logic [1:0] pin);
    logic [1:0] lvl;
    lvl = (g.dir & g.level) | (~g.dir & pin);
    gp_read = {4'h0, lvl, g.dir};
  endfunction

  assign pins_now = '{rst_n: reset_pin_n, cs_n: cs_n, rw: rw_wr_sdi,
                      strb: transfer_strobe_n, style: bus_style_select,
                      ser: serial_host_select, flt: line_out_float,
                      gpio: gpio_in, data: data_in, addr: addr};

  // ****************************************************
  // Next state
  // ****************************************************
  logic ready;
  logic par_rd_go;
  logic par_wr_end;
  logic sclk_rise;
  logic sclk_fall;
  logic [hcp_pkg::DATA_W-1:0] rd_val;
  logic [hcp_pkg::DATA_W-1:0] ser_byte;
  logic [hcp_pkg::DATA_W-1:0] gp_now;

  // GPIO register image as read back
  assign gp_now = gp_read(st.gpctl, st.s2.gpio);

  always_comb begin
    next_st = st;
    next_st.s1 = pins_now;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.reg_rd = 1'b0;
    next_st.reg_wr = 1'b0;
    ready = (st.state != hcp_pkg::HCP_BOOT);
    if (st.s2.style) begin
      par_rd_go = !st.s2.strb;
      par_wr_end = st.s2.rw && !st.s3.rw;
    end else begin
      par_rd_go = !st.s2.strb && st.s2.rw;
      par_wr_end = st.s2.strb && !st.s3.strb && !st.s2.rw;
    end
    sclk_rise = st.s2.strb && !st.s3.strb;
    sclk_fall = !st.s2.strb && st.s3.strb;
    rd_val = (st.addr == hcp_pkg::GPCTL_ADDR) ? gp_now : reg_rdata;
    ser_byte = {st.shift[6:0], st.s2.rw};

    // bus access enabled once chip select has been seen high
    if (st.s2.cs_n) begin
      next_st.cs_seen = 1'b1;
    end

    // Read data capture one cycle after the core sees the address
    if (st.rd_pend) begin
      next_st.rd_pend = 1'b0;
      next_st.rdata = rd_val;
      if (!st.s2.ser) begin
        next_st.drv = rd_val;
      end
    end

    case (st.state)
      hcp_pkg::HCP_BOOT: begin
        next_st.oe = '0;
        if (st.boot_cnt == hcp_pkg::BOOT_W'(READY_CYC - 1)) begin
          next_st.state = hcp_pkg::HCP_IDLE;
        end else begin
          next_st.boot_cnt = st.boot_cnt + 1'b1;
        end
      end
      hcp_pkg::HCP_IDLE: begin
        // bus ignored while chip select high
        if (st.s2.cs_n || !st.cs_seen) begin
          next_st.oe = '0;
          next_st.bitcnt = '0;
          next_st.ser_rd = 1'b0;
        end else if (st.s2.ser) begin
          if (sclk_rise && st.bitcnt != hcp_pkg::SER_END) begin
            next_st.shift = {st.shift[14:0], st.s2.rw};
            next_st.bitcnt = st.bitcnt + 1'b1;
            if (st.bitcnt == hcp_pkg::SER_CMD_LAST) begin
              next_st.addr = {st.shift[8:0], st.s2.rw};
              next_st.ser_rd = st.shift[hcp_pkg::SER_RD_POS];
              if (st.shift[hcp_pkg::SER_RD_POS]) begin
                next_st.rd_pend = 1'b1;
                next_st.reg_rd = 1'b1;
                next_st.bitcnt = hcp_pkg::SER_END;
              end
            end
            if (st.bitcnt == hcp_pkg::SER_WR_LAST && !st.ser_rd) begin
              next_st.wdata = ser_byte;
              if (st.addr == hcp_pkg::GPCTL_ADDR) begin
                next_st.gpctl.dir = ser_byte[hcp_pkg::GP_DIR_LSB +: 2];
                next_st.gpctl.level = ser_byte[hcp_pkg::GP_LEVEL_LSB +: 2];
              end else begin
                next_st.reg_wr = 1'b1;
              end
            end
          end
          // read data out on falling clock, bit 0 only
          if (sclk_fall && st.ser_rd) begin
            next_st.drv = {7'h00, st.rdata[7]};
            next_st.rdata = {st.rdata[6:0], 1'b0};
            next_st.oe = {7'h00, 1'b1};
          end
        end else begin
          // parallel read: address pins select, bus driven
          if (par_rd_go) begin
            next_st.addr = st.s2.addr;
            next_st.rd_pend = 1'b1;
            next_st.reg_rd = 1'b1;
            next_st.oe = '1;
            next_st.state = hcp_pkg::HCP_DONE;
          // parallel write sampled at strobe end
          end else if (par_wr_end) begin
            next_st.addr = st.s2.addr;
            next_st.wdata = st.s2.data;
            if (st.s2.addr == hcp_pkg::GPCTL_ADDR) begin
              next_st.gpctl.dir = st.s2.data[hcp_pkg::GP_DIR_LSB +: 2];
              next_st.gpctl.level = st.s2.data[hcp_pkg::GP_LEVEL_LSB +: 2];
            end else begin
              next_st.reg_wr = 1'b1;
            end
            next_st.state = hcp_pkg::HCP_DONE;
          end
        end
      end
      hcp_pkg::HCP_DONE: begin
        // one access per chip select low period
        if (!par_rd_go || st.s2.cs_n) begin
          next_st.oe = '0;
        end
        if (st.s2.cs_n) begin
          next_st.state = hcp_pkg::HCP_IDLE;
        end
      end
      default: begin
        next_st.state = hcp_pkg::HCP_BOOT;
        next_st.boot_cnt = '0;
      end
    endcase

    // reset of state, GPIO control, bus drive and access strobes after a long enough low on the pin
    if (!st.s2.rst_n) begin
      if (st.rst_cnt != hcp_pkg::RST_CNT_W'(hcp_pkg::RST_CYC)) begin
        next_st.rst_cnt = st.rst_cnt + 1'b1;
      end else begin
        next_st.state = hcp_pkg::HCP_BOOT;
        next_st.boot_cnt = '0;
        next_st.gpctl = '{level: hcp_pkg::GP_LEVEL_RST, dir: hcp_pkg::GP_DIR_RST};
        next_st.oe = '0;
        next_st.drv = '0;
        next_st.rd_pend = 1'b0;
        next_st.reg_rd = 1'b0;
        next_st.reg_wr = 1'b0;
        next_st.bitcnt = '0;
        next_st.ser_rd = 1'b0;
      end
    end else begin
      next_st.rst_cnt = '0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.state <= hcp_pkg::HCP_BOOT;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign data_out = st.drv;
  assign data_oe = st.oe;
  assign gpio_out = st.gpctl.level;
  assign gpio_oe = st.gpctl.dir;
  assign int_n_out = 1'b0;
  assign int_oe = |(int_flags & int_mask);
  assign tx_hiz = {hcp_pkg::LINK_N{st.s2.flt}};
  assign reg_addr = st.addr;
  assign reg_wdata = st.wdata;
  assign reg_wr = st.reg_wr;
  assign reg_rd = st.reg_rd;
  assign regs_ready = ready;

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  property p_reset_pulse;
    !reset_pin_n [*8] |=> !regs_ready;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("long reset low did not reset");

  property p_boot_quiet;
    !regs_ready |-> !reg_wr && !reg_rd && data_oe == 8'h00;
  endproperty
  a_boot_quiet: assert property (p_boot_quiet) else $error("access before ready");

  property p_gpio_dir;
    !st.gpctl.dir[0] |-> !gpio_oe[0] && gp_now[2] == st.s2.gpio[0];
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) else $error("input gpio not reported");

  property p_gpio_level;
    gpio_oe[1] |-> gp_now[3] == gpio_out[1];
  endproperty
  a_gpio_level: assert property (p_gpio_level) else $error("output gpio level wrong");

  property p_int_idle;
    (int_flags & int_mask) == 8'h00 |-> !int_oe && !int_n_out;
  endproperty
  a_int_idle: assert property (p_int_idle) else $error("interrupt without source");

  property p_par_bus;
    |data_oe[7:1] |-> !st.s3.ser && !st.s3.cs_n;
  endproperty
  a_par_bus: assert property (p_par_bus) else $error("data bus driven outside parallel read");

  property p_ser_pin;
    st.s2.ser && st.s3.ser |-> data_oe[7:1] == 7'h00;
  endproperty
  a_ser_pin: assert property (p_ser_pin) else $error("serial mode drove upper data pins");

  property p_sdo_fall;
    st.s2.ser && $changed(data_out[0]) |-> $past(sclk_fall) || $past(st.rd_pend);
  endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("serial out changed off falling edge");

  property p_float;
    line_out_float [*2] |=> tx_hiz == 4'hf;
  endproperty
  a_float: assert property (p_float) else $error("line outputs not floated");

endmodule // hcp_host_control_port

// ===== hcp_host_model.sv
// Host processor model driving the parallel and serial bus pins
`timescale 1ns/1ns
module hcp_host_model (
  // Clock
  input wire logic clock,
  // Bus pins
  output logic cs_n,
  output logic [hcp_pkg::ADDR_W-1:0] addr,
  output logic [hcp_pkg::DATA_W-1:0] data_in,
  input wire logic [hcp_pkg::DATA_W-1:0] data_out,
  input wire logic [hcp_pkg::DATA_W-1:0] data_oe,
  output logic rw_wr_sdi,
  output logic transfer_strobe_n,
  // Mode straps
  output logic bus_style_select,
  output logic serial_host_select
);
  logic [7:0] drv;
  logic drv_en;
  logic [7:0] flt = 8'h5a;
  // ********************************
  // Data bus wire
  // ********************************
  // shared wire level
  always_comb begin
    data_in = serial_host_select ? {7'h00, flt[0]} : flt;
    if (drv_en)
      data_in = drv;
    data_in = (data_oe & data_out) | (~data_oe & data_in);
  end
  // Released lines keep changing
  always @(posedge clock) begin
    flt <= ~flt;
  end
  initial begin
    cs_n = 1'b1;
    addr = 10'h000;
    drv = 8'h00;
    drv_en = 1'b0;
    rw_wr_sdi = 1'b1;
    transfer_strobe_n = 1'b1;
    bus_style_select = 1'b0;
    serial_host_select = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic set_mode(input logic ser, input logic style);
    cs_n = 1'b1;
    serial_host_select = ser;
    bus_style_select = style;
    transfer_strobe_n = ~ser;
    rw_wr_sdi = 1'b1;
    addr = 10'h000;
    step(6);
  endtask
  task automatic cs_end();
    step(4);
    cs_n = 1'b1;
    drv_en = 1'b0;
    rw_wr_sdi = 1'b1;
    step(5);
  endtask
  task automatic par_write(input logic sel, input logic [9:0] a, input logic [7:0] d);
    cs_n = ~sel;
    addr = a;
    drv = d;
    drv_en = 1'b1;
    rw_wr_sdi = bus_style_select;
    step(2);
    if (bus_style_select)
      rw_wr_sdi = 1'b0;
    else
      transfer_strobe_n = 1'b0;
    step(4);
    if (bus_style_select)
      rw_wr_sdi = 1'b1;
    else
      transfer_strobe_n = 1'b1;
    cs_end();
  endtask
  task automatic par_read(input logic [9:0] a, output logic [7:0] d);
    d = 8'hxx;
    cs_n = 1'b0;
    addr = a;
    rw_wr_sdi = 1'b1;
    step(2);
    transfer_strobe_n = 1'b0;
    for (int i = 0; i < 20 && data_oe !== 8'hff; i++)
      step(1);
    step(2);
    if (data_oe === 8'hff)
      d = data_in;
    transfer_strobe_n = 1'b1;
    cs_end();
  endtask
  // drive on fall, sample on rise
  task automatic ser_frame(input logic [23:0] f, output logic [7:0] d);
    d = 8'hxx;
    cs_n = 1'b0;
    #37;
    for (int i = 23; i >= 0; i--) begin
      rw_wr_sdi = f[i];
      #80;
      transfer_strobe_n = 1'b1;
      d = {d[6:0], data_in[0]};
      #80;
      transfer_strobe_n = 1'b0;
    end
    #29;
    cs_end();
  endtask
endmodule // hcp_host_model

// ===== hcp_host_control_port_tb.sv
// Self-checking bench of the host control port
`timescale 1ns/1ns
module hcp_host_control_port_tb;
  localparam int RDY = 20;
  logic clock, arst_n, reset_pin_n, cs_n, rw_wr_sdi, transfer_strobe_n;
  logic bus_style_select, serial_host_select, int_n_out, int_oe, line_out_float;
  logic reg_wr, reg_rd, regs_ready;
  logic [9:0] addr, reg_addr;
  logic [7:0] data_in, data_out, data_oe, int_flags, int_mask, reg_wdata, reg_rdata;
  logic [1:0] gpio_in, gpio_out, gpio_oe, gp_ext;
  logic [3:0] tx_hiz;
  logic [7:0] mem [0:1023];
  int n_mismatch, compares;
  int n_wr = 0;
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & gp_ext);
  assign reg_rdata = mem[reg_addr];
  always @(posedge clock) begin
    if (reg_wr === 1'b1) begin
      mem[reg_addr] <= reg_wdata;
      n_wr <= n_wr + 1;
    end
  end
  hcp_host_control_port #(.READY_CYC(RDY)) i_dut (
    .clock(clock), .arst_n(arst_n), .reset_pin_n(reset_pin_n), .cs_n(cs_n), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .rw_wr_sdi(rw_wr_sdi),
    .transfer_strobe_n(transfer_strobe_n), .bus_style_select(bus_style_select),
    .serial_host_select(serial_host_select), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .int_flags(int_flags), .int_mask(int_mask), .int_n_out(int_n_out),
    .int_oe(int_oe), .line_out_float(line_out_float), .tx_hiz(tx_hiz), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .regs_ready(regs_ready));
  hcp_host_model i_host (
    .clock(clock), .cs_n(cs_n), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .rw_wr_sdi(rw_wr_sdi), .transfer_strobe_n(transfer_strobe_n),
    .bus_style_select(bus_style_select), .serial_host_select(serial_host_select));
  function automatic logic [7:0] pat(input logic [9:0] a);
    return a[7:0] ^ 8'h3c;
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wait_ready(output int c);
    c = 0;
    while (regs_ready !== 1'b1 && c < 400) begin
      i_host.step(1);
      c++;
    end
    if (c >= 400) begin
      n_mismatch++;
      give_verdict();
    end
  endtask
  // ********************************
  // Scenarios
  // ********************************
  task automatic t_par();
    int n0;
    logic [7:0] d;
    for (int s = 0; s < 2; s++) begin
      i_host.set_mode(1'b0, s[0]);
      n0 = n_wr;
      i_host.par_write(1'b1, 10'h155 + 10'(s), 8'ha5 ^ 8'(s));
      check("wr count", 8'(n_wr - n0), 8'h01);
      check("wr data", mem[10'h155 + 10'(s)], 8'ha5 ^ 8'(s));
      i_host.par_read(10'h2a0 + 10'(s), d);
      check("rd core", d, pat(10'h2a0 + 10'(s)));
      n0 = n_wr;
      i_host.par_write(1'b0, 10'h155, 8'h00);
      check("cs high", 8'(n_wr - n0), 8'h00);
    end
    $display("test par done");
  endtask
  task automatic t_gpio();
    logic [7:0] d;
    i_host.set_mode(1'b0, 1'b1);
    gp_ext = 2'b10;
    i_host.par_write(1'b1, hcp_pkg::GPCTL_ADDR, 8'h05);
    check("gp oe", {6'h00, gpio_oe}, 8'h01);
    check("gp out", {7'h00, gpio_out[0]}, 8'h01);
    i_host.par_read(hcp_pkg::GPCTL_ADDR, d);
    check("gp rd", d, 8'h0d);
    gp_ext = 2'b00;
    i_host.par_read(hcp_pkg::GPCTL_ADDR, d);
    check("gp rd", d, 8'h05);
    i_host.par_write(1'b1, hcp_pkg::GPCTL_ADDR, 8'h02);
    gp_ext = 2'b11;
    check("gp pins", {4'h0, gpio_oe, gpio_out}, 8'h08);
    i_host.par_read(hcp_pkg::GPCTL_ADDR, d);
    check("gp rd", d, 8'h06);
    $display("test gpio done");
  endtask
  task automatic t_pin();
    int c;
    reset_pin_n = 1'b0;
    i_host.step(3);
    reset_pin_n = 1'b1;
    i_host.step(10);
    check("short pin", {6'h00, gpio_oe}, 8'h02);
    reset_pin_n = 1'b0;
    i_host.step(10);
    reset_pin_n = 1'b1;
    i_host.step(4);
    check("long pin", {6'h00, gpio_oe}, 8'h00);
    check("not ready", {7'h00, regs_ready}, 8'h00);
    wait_ready(c);
    i_host.par_write(1'b1, hcp_pkg::GPCTL_ADDR, 8'h03);
    check("gp dir", {6'h00, gpio_oe}, 8'h03);
    arst_n = 1'b0;
    i_host.step(2);
    check("arst gp", {6'h00, gpio_oe}, 8'h00);
    arst_n = 1'b1;
    i_host.step(2);
    check("arst rdy", {7'h00, regs_ready}, 8'h00);
    wait_ready(c);
    $display("test pin reset done");
  endtask
  task automatic t_ser();
    logic [7:0] d;
    i_host.set_mode(1'b1, 1'b0);
    i_host.ser_frame({1'b0, 5'h00, 10'h0c3, 8'h96}, d);
    check("ser wr", mem[10'h0c3], 8'h96);
    i_host.ser_frame({1'b1, 5'h00, 10'h0c3, 8'h00}, d);
    check("ser rd", d, 8'h96);
    i_host.ser_frame({1'b1, 5'h00, 10'h2a7, 8'h00}, d);
    check("ser rd", d, pat(10'h2a7));
    i_host.ser_frame({1'b0, 5'h00, hcp_pkg::GPCTL_ADDR, 8'h0e}, d);
    check("ser gp", {4'h0, gpio_oe, gpio_out}, 8'h0b);
    i_host.ser_frame({1'b1, 5'h00, hcp_pkg::GPCTL_ADDR, 8'h00}, d);
    check("ser gp rd", d, 8'h0e);
    $display("test serial done");
  endtask
  task automatic t_int_float();
    for (int k = 0; k < 5; k++) begin
      int_flags = (k == 4) ? 8'h00 : 8'h81;
      int_mask = 8'h7e >> k;
      i_host.step(1);
      check("int oe", {7'h00, int_oe}, {7'h00, k > 0 && k < 4});
      check("int lvl", {7'h00, int_n_out}, 8'h00);
    end
    line_out_float = 1'b1;
    i_host.step(3);
    check("hiz on", {4'h0, tx_hiz}, 8'h0f);
    line_out_float = 1'b0;
    i_host.step(3);
    check("hiz off", {4'h0, tx_hiz}, 8'h00);
    $display("test int and float done");
  endtask
  initial begin
    int c;
    arst_n = 1'b0;
    reset_pin_n = 1'b1;
    gp_ext = 2'b11;
    int_flags = 8'h00;
    int_mask = 8'h00;
    line_out_float = 1'b0;
    n_mismatch = 0;
    compares = 0;
    for (int i = 0; i < 1024; i++)
      mem[i] = pat(10'(i));
    repeat (12) @(posedge clock);
    #2;
    arst_n = 1'b1;
    wait_ready(c);
    check("boot wait", {7'h00, c >= RDY}, 8'h01);
    t_par();
    t_gpio();
    t_pin();
    t_ser();
    t_int_float();
    give_verdict();
  end
endmodule // hcp_host_control_port_tb
